// >>> src/spra_ack_sync.sv
// Acknowledge tracker: an update takes effect a fixed time after its write,
// then its value appears in the ack register. Assumes a synchronous reset.
`timescale 1ns/1ps
module spra_ack_sync #(
  parameter int ACK_CYC = spra_pkg::ACK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  spra_upd_if.unit u
);
  logic        pend_q;
  logic [7:0]  cnt_q;
  logic [31:0] data_q;
  logic [31:0] ack_q;

  if (ACK_CYC < 1 || ACK_CYC > 255) begin : g_bad
    $error("spra_ack_sync: ACK_CYC out of range");
  end

  // A new write restarts the wait so the ack always shows the latest value
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      cnt_q  <= 8'h00;
      data_q <= spra_pkg::RESET_VALUE;
    end else if (u.req) begin
      pend_q <= 1'b1;
      cnt_q  <= 8'(ACK_CYC - 1);
      data_q <= u.data;
    end else if (pend_q && cnt_q == 8'h00) begin
      pend_q <= 1'b0;
    end else if (pend_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= spra_pkg::RESET_VALUE;
    end else if (pend_q && cnt_q == 8'h00 && !u.req) begin
      ack_q <= data_q;
    end
  end

  assign u.ack  = ack_q;
  assign u.busy = pend_q;

  ack_bound_a: assert property (@(posedge clk) disable iff (rst)
    u.req ##1 (!u.req)[*2] |=> !pend_q)
    else $error("update ack not completed in time");
endmodule : spra_ack_sync

// >>> src/spra_pkg.sv
// Shared offsets, field masks, reset values and timing for the register front end.
// Assumes a 10 MHz clock; offsets are relative to the integrator's base address.
package spra_pkg;
  localparam int          CLK_PERIOD_NS   = 100;
  // Time for a control update to take effect before it shows in its ack register
  localparam int          ACK_TIME_NS     = 200;
  localparam int          ACK_CYCLES      = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] WINDOW_BYTES    = 32'h0000_4000;
  localparam int          OFF_W           = 14;
  // Register offsets
  localparam logic [13:0] OFF_IMPL_ID     = 14'h0000;
  localparam logic [13:0] OFF_FEAT_ID4    = 14'h0010;
  localparam logic [13:0] OFF_UNIT_STATUS = 14'h0040;
  localparam logic [13:0] OFF_ALT_BYPASS  = 14'h0048;
  localparam logic [13:0] OFF_XLATE_LO    = 14'h0100;
  localparam logic [13:0] OFF_XLATE_HI    = 14'h01FC;
  localparam logic [13:0] OFF_S_CTRL0     = 14'h0020;
  localparam logic [13:0] OFF_S_CTRL0_ACK = 14'h0024;
  localparam logic [13:0] OFF_S_INIT      = 14'h003C;
  localparam logic [13:0] OFF_S_IRQ_EN    = 14'h0050;
  localparam logic [13:0] OFF_S_IRQ_ACK   = 14'h0054;
  localparam logic [13:0] OFF_S_GERR      = 14'h0060;
  localparam logic [13:0] OFF_S_GERR_ACK  = 14'h0064;
  localparam logic [13:0] OFF_S_STRTAB_LO = 14'h0080;
  localparam logic [13:0] OFF_S_STRTAB_HI = 14'h0084;
  localparam logic [13:0] OFF_PERF_CTRL   = 14'h2000;
  localparam logic [13:0] OFF_PERF_CNT_LO = 14'h2008;
  localparam logic [13:0] OFF_PERF_CNT_HI = 14'h200C;
  localparam logic [13:0] OFF_PERF_IRQ_ST = 14'h2010;
  // Implemented field masks; everything else is reserved
  localparam logic [31:0] CTRL0_MASK      = 32'h0000_001F;
  localparam logic [31:0] IRQ_EN_MASK     = 32'h0000_0007;
  localparam logic [31:0] STRTAB_LO_MASK  = 32'hFFFF_FFC0;
  localparam logic [31:0] STRTAB_HI_MASK  = 32'h0000_FFFF;
  localparam int          INIT_BIT        = 0;
  localparam int          PERF_EN_BIT     = 0;
  localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
endpackage : spra_pkg

// >>> src/spra_top.sv
// Programming-port register front end: decode, secure filtering, control
// registers with ack tracking, global error status and a perf counter group.
// Assumes one clock, synchronous reset, and a master that never overlaps strobes.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Registers are reachable only through this single 32-bit programming port.
// - 64-bit registers are two independent 32-bit halves, no atomicity.
// - Unmapped or reserved offsets read zero; writes there do nothing.
// - Non-secure access to secure registers reads zero and writes are ignored.
// - Reset clears every register bit unless stated otherwise.
// - Reserved bits read zero and ignore writes.
// - Unimplemented architectural register locations read zero and ignore writes.
// - Perf counter group registers exist, except its interrupt configuration and status.
// - Offsets decode relative to an integrator-chosen base address.
// - Control zero ack register shows the update once it has taken effect.
// - Interrupt enable ack register shows new enables once the update completes.
// - Init control invalidates all secure cached state when triggered.
// - Global errors show in status; software acknowledges via a separate register.
module spra_top #(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
  parameter int          ERR_W     = 8,
  // Identification value is arbitrary
  parameter logic [31:0] IMPL_ID   = 32'h0000_0A5A
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [31:0]        addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  input  wire logic               sec,
  output logic      [31:0]        rdata,
  output logic      [31:0]        ctrl0_eff,
  output logic      [31:0]        irq_en_eff,
  output logic      [63:0]        strtab_base,
  output logic                    inv_req,
  input  wire logic               inv_done,
  input  wire logic [ERR_W-1:0]   gerr_event,
  output logic      [ERR_W-1:0]   gerr_active,
  input  wire logic               perf_event
);
  if (ERR_W < 1 || ERR_W > 32) begin : g_bad
    $error("spra_top: ERR_W must be 1 to 32");
  end

  localparam logic [31:0] GERR_MASK = 32'((64'h1 << ERR_W) - 64'h1);

  logic [31:0]        off_full;
  logic               in_win;
  logic [13:0]        off;
  logic               sec_reg;
  logic               allowed;
  logic               wr_ok;
  logic [31:0]        rd_val;
  logic [31:0]        rdata_q;
  logic [31:0]        ctrl0_q;
  logic [31:0]        irq_en_q;
  logic [31:0]        strtab_lo_q;
  logic [31:0]        strtab_hi_q;
  logic               init_busy_q;
  logic [ERR_W-1:0]   gerr_q;
  logic [ERR_W-1:0]   gerr_ack_q;
  logic [ERR_W-1:0]   gerr_ack_d;
  logic               perf_en_q;
  logic [63:0]        perf_cnt_q;

  spra_upd_if ctrl0_upd ();
  spra_upd_if irq_upd ();

  // Single decode point for the one programming port; no other path exists
  assign off_full = addr - BASE_ADDR;
  assign in_win   = (addr >= BASE_ADDR) && (off_full < spra_pkg::WINDOW_BYTES);
  assign off      = off_full[spra_pkg::OFF_W-1:0];
  assign sec_reg  = in_win && off >= spra_pkg::OFF_S_CTRL0 && off < spra_pkg::OFF_PERF_CTRL;
  assign allowed  = in_win && (!sec_reg || sec);
  assign wr_ok    = wr && allowed;

  // Read mux; anything not listed, including unimplemented locations, reads zero
  always_comb begin
    rd_val = 32'h0000_0000;
    if (allowed) begin
      unique case (off)
        spra_pkg::OFF_IMPL_ID:     rd_val = IMPL_ID;
        spra_pkg::OFF_S_CTRL0:     rd_val = ctrl0_q;
        spra_pkg::OFF_S_CTRL0_ACK: rd_val = ctrl0_upd.ack;
        spra_pkg::OFF_S_INIT:      rd_val = {31'h0, init_busy_q};
        spra_pkg::OFF_S_IRQ_EN:    rd_val = irq_en_q;
        spra_pkg::OFF_S_IRQ_ACK:   rd_val = irq_upd.ack;
        spra_pkg::OFF_S_GERR:      rd_val = 32'(gerr_q);
        spra_pkg::OFF_S_GERR_ACK:  rd_val = 32'(gerr_ack_q);
        spra_pkg::OFF_S_STRTAB_LO: rd_val = strtab_lo_q;
        spra_pkg::OFF_S_STRTAB_HI: rd_val = strtab_hi_q;
        spra_pkg::OFF_PERF_CTRL:   rd_val = {31'h0, perf_en_q};
        spra_pkg::OFF_PERF_CNT_LO: rd_val = perf_cnt_q[31:0];
        spra_pkg::OFF_PERF_CNT_HI: rd_val = perf_cnt_q[63:32];
        default:                   rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= spra_pkg::RESET_VALUE;
    end else begin
      rdata_q <= rd ? rd_val : 32'h0000_0000;
    end
  end
  assign rdata = rdata_q;

  // Control registers; reserved bits masked on write
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0_q  <= spra_pkg::RESET_VALUE;
      irq_en_q <= spra_pkg::RESET_VALUE;
    end else if (wr_ok && off == spra_pkg::OFF_S_CTRL0) begin
      ctrl0_q <= wdata & spra_pkg::CTRL0_MASK;
    end else if (wr_ok && off == spra_pkg::OFF_S_IRQ_EN) begin
      irq_en_q <= wdata & spra_pkg::IRQ_EN_MASK;
    end
  end

  assign ctrl0_upd.req  = wr_ok && off == spra_pkg::OFF_S_CTRL0;
  assign ctrl0_upd.data = wdata & spra_pkg::CTRL0_MASK;
  assign irq_upd.req    = wr_ok && off == spra_pkg::OFF_S_IRQ_EN;
  assign irq_upd.data   = wdata & spra_pkg::IRQ_EN_MASK;

  spra_ack_sync #(.ACK_CYC(spra_pkg::ACK_CYCLES)) u_ctrl0_ack (
    .clk (clk),
    .rst (rst),
    .u   (ctrl0_upd)
  );
  spra_ack_sync #(.ACK_CYC(spra_pkg::ACK_CYCLES)) u_irq_ack (
    .clk (clk),
    .rst (rst),
    .u   (irq_upd)
  );

  // The logic behind sees only values that have taken effect
  assign ctrl0_eff  = ctrl0_upd.ack;
  assign irq_en_eff = irq_upd.ack;

  // Halves written independently; software must not assume a 64-bit snapshot
  always_ff @(posedge clk) begin
    if (rst) begin
      strtab_lo_q <= spra_pkg::RESET_VALUE;
    end else if (wr_ok && off == spra_pkg::OFF_S_STRTAB_LO) begin
      strtab_lo_q <= wdata & spra_pkg::STRTAB_LO_MASK;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      strtab_hi_q <= spra_pkg::RESET_VALUE;
    end else if (wr_ok && off == spra_pkg::OFF_S_STRTAB_HI) begin
      strtab_hi_q <= wdata & spra_pkg::STRTAB_HI_MASK;
    end
  end
  assign strtab_base = {strtab_hi_q, strtab_lo_q};

  // Init trigger holds until the invalidation engine reports done; a write
  // of zero or a repeat trigger while busy has no effect
  always_ff @(posedge clk) begin
    if (rst) begin
      init_busy_q <= 1'b0;
    end else if (init_busy_q && inv_done) begin
      init_busy_q <= 1'b0;
    end else if (wr_ok && off == spra_pkg::OFF_S_INIT && wdata[spra_pkg::INIT_BIT]) begin
      init_busy_q <= 1'b1;
    end
  end
  assign inv_req = init_busy_q;

  // Error bit is active while status differs from ack. An event on an
  // inactive bit toggles status; the ack written this cycle is counted first
  // so an event in the clearing cycle is not lost
  always_comb begin
    gerr_ack_d = gerr_ack_q;
    if (wr_ok && off == spra_pkg::OFF_S_GERR_ACK) begin
      gerr_ack_d = wdata[ERR_W-1:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      gerr_ack_q <= '0;
    end else begin
      gerr_ack_q <= gerr_ack_d;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      gerr_q <= '0;
    end else begin
      gerr_q <= gerr_q ^ (gerr_event & ~(gerr_q ^ gerr_ack_d));
    end
  end
  assign gerr_active = gerr_q ^ gerr_ack_q;

  // Perf counter group: enable and a 64-bit event counter; the interrupt
  // configuration and status slots stay read-as-zero
  always_ff @(posedge clk) begin
    if (rst) begin
      perf_en_q <= 1'b0;
    end else if (wr_ok && off == spra_pkg::OFF_PERF_CTRL) begin
      perf_en_q <= wdata[spra_pkg::PERF_EN_BIT];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      perf_cnt_q <= 64'h0000_0000_0000_0000;
    end else if (wr_ok && off == spra_pkg::OFF_PERF_CNT_LO) begin
      perf_cnt_q[31:0] <= wdata;
    end else if (wr_ok && off == spra_pkg::OFF_PERF_CNT_HI) begin
      perf_cnt_q[63:32] <= wdata;
    end else if (perf_en_q && perf_event) begin
      perf_cnt_q <= perf_cnt_q + 64'h1;
    end
  end

  // Checks
  unmapped_rd_a: assert property (@(posedge clk) disable iff (rst)
    rd && !in_win |=> rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");
  ns_secure_a: assert property (@(posedge clk) disable iff (rst)
    wr && sec_reg && !sec && off == spra_pkg::OFF_S_CTRL0 |=> $stable(ctrl0_q))
    else $error("non-secure write changed secure register");
  reset_clear_a: assert property (@(posedge clk)
    rst |=> ctrl0_q == 32'h0 && irq_en_q == 32'h0 && !inv_req && gerr_q == '0)
    else $error("register not cleared by reset");
  rsvd_bits_a: assert property (@(posedge clk) disable iff (rst)
    (ctrl0_q & ~spra_pkg::CTRL0_MASK) == 32'h0 && (irq_en_q & ~spra_pkg::IRQ_EN_MASK) == 32'h0)
    else $error("reserved bit set");
  unimpl_rd_a: assert property (@(posedge clk) disable iff (rst)
    rd && (off == spra_pkg::OFF_FEAT_ID4 || off == spra_pkg::OFF_UNIT_STATUS ||
    off == spra_pkg::OFF_ALT_BYPASS || off == spra_pkg::OFF_PERF_IRQ_ST ||
    (off >= spra_pkg::OFF_XLATE_LO && off <= spra_pkg::OFF_XLATE_HI)) |=> rdata == 32'h0)
    else $error("unimplemented location read nonzero");
  perf_count_a: assert property (@(posedge clk) disable iff (rst)
    perf_en_q && perf_event && !wr |=> perf_cnt_q == $past(perf_cnt_q) + 64'h1)
    else $error("perf counter missed an event");
  base_rel_a: assert property (@(posedge clk) disable iff (rst)
    rd && addr == BASE_ADDR |=> rdata == IMPL_ID)
    else $error("id not at base offset");
  ctrl0_ack_a: assert property (@(posedge clk) disable iff (rst)
    ctrl0_upd.req ##1 (!ctrl0_upd.req)[*2] |=> ctrl0_upd.ack == ctrl0_q)
    else $error("control ack did not follow write");
  irq_ack_a: assert property (@(posedge clk) disable iff (rst)
    irq_upd.req ##1 (!irq_upd.req)[*2] |=> irq_upd.ack == irq_en_q)
    else $error("irq enable ack did not follow write");
  init_hold_a: assert property (@(posedge clk) disable iff (rst)
    inv_req && !inv_done |=> inv_req)
    else $error("invalidate request dropped before done");
  gerr_set_a: assert property (@(posedge clk) disable iff (rst)
    gerr_event[0] && !wr && !gerr_active[0] |=> gerr_active[0])
    else $error("error event not recorded");
  rd_once_a: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 32'h0)
    else $error("read data stood past its cycle");
  half_indep_a: assert property (@(posedge clk) disable iff (rst)
    wr && off == spra_pkg::OFF_S_STRTAB_LO |=> $stable(strtab_hi_q))
    else $error("low half write disturbed high half");
  hi_indep_a: assert property (@(posedge clk) disable iff (rst)
    wr && off == spra_pkg::OFF_S_STRTAB_HI |=> $stable(strtab_lo_q))
    else $error("high half write disturbed low half");
  ns_rd_zero_a: assert property (@(posedge clk) disable iff (rst)
    rd && sec_reg && !sec |=> rdata == 32'h0000_0000)
    else $error("non-secure read of secure register returned data");
  irq_ns_a: assert property (@(posedge clk) disable iff (rst)
    wr && !sec && off == spra_pkg::OFF_S_IRQ_EN |=> $stable(irq_en_q))
    else $error("non-secure write changed interrupt enables");
  perf_wr_win_a: assert property (@(posedge clk) disable iff (rst)
    wr_ok && off == spra_pkg::OFF_PERF_CNT_LO |=> perf_cnt_q[31:0] == $past(wdata))
    else $error("counter write lost to a count");
  // Busy rises the cycle after the write, so a second write restarts the wait rather than racing it
  ctrl0_busy_a: assert property (@(posedge clk) disable iff (rst)
    ctrl0_upd.req |=> ctrl0_upd.busy)
    else $error("control update not tracked");
  irq_busy_a: assert property (@(posedge clk) disable iff (rst)
    irq_upd.req |=> irq_upd.busy)
    else $error("irq enable update not tracked");
  init_start_a: assert property (@(posedge clk) disable iff (rst)
    wr_ok && off == spra_pkg::OFF_S_INIT && wdata[spra_pkg::INIT_BIT] && !inv_req
    |=> inv_req)
    else $error("init trigger did not start invalidation");
  gerr_ack_wr_a: assert property (@(posedge clk) disable iff (rst)
    wr_ok && off == spra_pkg::OFF_S_GERR_ACK
    |=> 32'(gerr_ack_q) == ($past(wdata) & GERR_MASK))
    else $error("error ack write not stored");
  // An event must survive a clearing ack written in the same cycle
  gerr_set_wins_a: assert property (@(posedge clk) disable iff (rst)
    gerr_event[0] && wr_ok && off == spra_pkg::OFF_S_GERR_ACK && wdata[0] == gerr_q[0]
    |=> gerr_active[0])
    else $error("error event lost to a clear");

  ctrl_upd_c: cover property (@(posedge clk) disable iff (rst)
    ctrl0_upd.req ##[1:4] ctrl0_upd.ack != 32'h0);
  gerr_ack_c: cover property (@(posedge clk) disable iff (rst)
    gerr_active[0] ##[1:20] !gerr_active[0]);
  init_c: cover property (@(posedge clk) disable iff (rst)
    inv_req ##[1:20] !inv_req);
  ns_block_c: cover property (@(posedge clk) disable iff (rst)
    rd && sec_reg && !sec);
  gerr_win_c: cover property (@(posedge clk) disable iff (rst)
    gerr_event[0] && wr_ok && off == spra_pkg::OFF_S_GERR_ACK);
endmodule : spra_top

// >>> src/spra_upd_if.sv
// Carries one control update from the register file to its acknowledge tracker.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface spra_upd_if;
  logic        req;
  logic [31:0] data;
  logic [31:0] ack;
  logic        busy;
  modport ctl  (output req, output data, input ack, input busy);
  modport unit (input req, input data, output ack, output busy);
endinterface : spra_upd_if

// >>> test/spra_inv_model.sv
// Far-side invalidation engine: answers each invalidate request with
// a one-cycle done pulse lag plus one cycles after the request rises.
`timescale 1ns/1ps
module spra_inv_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] lag,
  input  wire logic       inv_req,
  output logic            inv_done
);
  logic [7:0] cnt_q;

  // Count saturates at 8'hFF instead of wrapping back to lag, so one request never sees two done pulses
  always_ff @(posedge clk) begin
    if (rst || !inv_req) begin
      cnt_q    <= 8'h00;
      inv_done <= 1'b0;
    end else begin
      cnt_q    <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
      inv_done <= (cnt_q == lag);
    end
  end
endmodule : spra_inv_model

// >>> test/spra_top_bench.sv
// Self-checking bench for the programming-port register front end.
// Assumes the package, the design and the invalidation model compile first.
`timescale 1ns/1ps
module spra_top_bench;
  localparam logic [31:0] BASE = 32'h4000_0000;
  localparam logic [31:0] ID   = 32'h0000_0A5A; // Arbitrary value
  logic        clk, rst, wr, rd, sec, inv_req, inv_done, perf_event;
  logic [31:0] addr, wdata, rdata, ctrl0_eff, irq_en_eff;
  logic [63:0] strtab_base;
  logic [7:0]  gerr_event, gerr_active, lag;
  int          mismatches, samples_checked;

  spra_top #(.BASE_ADDR(BASE), .ERR_W(8), .IMPL_ID(ID)) spra_top_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .sec(sec), .rdata(rdata), .ctrl0_eff(ctrl0_eff), .irq_en_eff(irq_en_eff),
    .strtab_base(strtab_base), .inv_req(inv_req), .inv_done(inv_done),
    .gerr_event(gerr_event), .gerr_active(gerr_active), .perf_event(perf_event));
  spra_inv_model spra_inv_model_inst (
    .clk(clk), .rst(rst), .lag(lag), .inv_req(inv_req), .inv_done(inv_done));

  always #50 clk = ~clk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : clks

  task automatic wr_reg(input logic [15:0] o, input logic [31:0] d, input logic s);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= BASE + {16'h0000, o};
    wdata <= d;
    sec   <= s;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] o, input logic s, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= BASE + {16'h0000, o};
    sec  <= s;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  task automatic t_reset;
    chk({ctrl0_eff, irq_en_eff}, 64'h0);
    chk(strtab_base, 64'h0);
    chk({inv_req, gerr_active}, 64'h0);
    rd_chk(16'h0000, 1'b1, ID);
    clks(1);
    chk(rdata, 64'h0);
    rd_chk(16'h0020, 1'b1, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ack;
    logic [15:0] o;
    logic [31:0] m;
    for (int i = 0; i < 2; i++) begin
      o = (i == 0) ? 16'h0020 : 16'h0050;
      m = (i == 0) ? 32'h0000_001F : 32'h0000_0007;
      wr_reg(o, 32'hFFFF_FFFF, 1'b1);
      clks(1);
      chk((i == 0) ? ctrl0_eff : irq_en_eff, 64'h0);
      clks(1);
      chk((i == 0) ? ctrl0_eff : irq_en_eff, {32'h0, m});
      rd_chk(o, 1'b1, m);
      rd_chk(o + 16'h0004, 1'b1, m);
    end
    $display("test ack done");
  endtask : t_ack

  task automatic t_nonsec;
    wr_reg(16'h0020, 32'h0, 1'b0);
    rd_chk(16'h0020, 1'b0, 32'h0);
    rd_chk(16'h0020, 1'b1, 32'h0000_001F);
    $display("test nonsecure done");
  endtask : t_nonsec

  task automatic t_holes;
    logic [15:0] offs[8] = '{16'h0010, 16'h0040, 16'h0048, 16'h0100,
                             16'h01FC, 16'h2010, 16'h1000, 16'h4020};
    foreach (offs[i]) begin
      wr_reg(offs[i], 32'hFFFF_FFFF, 1'b1);
      rd_chk(offs[i], 1'b1, 32'h0);
    end
    // The out-of-window write would alias control zero if the window limit were ignored
    rd_chk(16'h0020, 1'b1, 32'h0000_001F);
    $display("test holes done");
  endtask : t_holes

  task automatic t_halves;
    wr_reg(16'h0080, 32'hFFFF_FFFF, 1'b1);
    rd_chk(16'h0084, 1'b1, 32'h0);
    chk(strtab_base, 64'h0000_0000_FFFF_FFC0);
    wr_reg(16'h0084, 32'hFFFF_FFFF, 1'b1);
    rd_chk(16'h0084, 1'b1, 32'h0000_FFFF);
    rd_chk(16'h0080, 1'b1, 32'hFFFF_FFC0);
    $display("test halves done");
  endtask : t_halves

  task automatic t_init;
    int n;
    wr_reg(16'h003C, 32'h1, 1'b1);
    clks(1);
    chk(inv_req, 64'h1);
    rd_chk(16'h003C, 1'b1, 32'h1);
    for (n = 0; n < 30 && inv_req !== 1'b0; n++) begin
      clks(1);
    end
    if (n == 30) begin
      mismatches++;
      $display("unexpected %0t: invalidate never ends", $time);
      complete_run();
    end
    rd_chk(16'h003C, 1'b1, 32'h0);
    $display("test init done");
  endtask : t_init

  task automatic t_gerr;
    @(posedge clk);
    gerr_event <= 8'h05;
    @(posedge clk);
    gerr_event <= 8'h00;
    clks(1);
    chk(gerr_active, 64'h05);
    rd_chk(16'h0060, 1'b1, 32'h05);
    rd_chk(16'h0064, 1'b1, 32'h0);
    wr_reg(16'h0064, 32'h05, 1'b1);
    clks(1);
    chk(gerr_active, 64'h0);
    @(posedge clk);
    gerr_event <= 8'h01;
    @(posedge clk);
    gerr_event <= 8'h00;
    clks(1);
    chk(gerr_active, 64'h01);
    // Clearing write and a new event in one cycle: the event must survive
    @(posedge clk);
    gerr_event <= 8'h01;
    wr         <= 1'b1;
    addr       <= BASE + 32'h0000_0064;
    wdata      <= 32'h0000_0004;
    sec        <= 1'b1;
    @(posedge clk);
    gerr_event <= 8'h00;
    wr         <= 1'b0;
    clks(1);
    chk(gerr_active, 64'h01);
    rd_chk(16'h0060, 1'b1, 32'h05);
    $display("test errors done");
  endtask : t_gerr

  task automatic t_perf;
    wr_reg(16'h2000, 32'h1, 1'b0);
    @(posedge clk);
    perf_event <= 1'b1;
    repeat (4) @(posedge clk);
    perf_event <= 1'b0;
    rd_chk(16'h2008, 1'b0, 32'h4);
    rd_chk(16'h200C, 1'b0, 32'h0);
    rd_chk(16'h2000, 1'b0, 32'h1);
    // A carry out of the low half must reach the high half
    wr_reg(16'h2008, 32'hFFFF_FFFF, 1'b0);
    rd_chk(16'h2008, 1'b0, 32'hFFFF_FFFF);
    @(posedge clk);
    perf_event <= 1'b1;
    @(posedge clk);
    perf_event <= 1'b0;
    rd_chk(16'h2008, 1'b0, 32'h0);
    rd_chk(16'h200C, 1'b0, 32'h1);
    $display("test perf done");
  endtask : t_perf

  // Reset in mid-run must clear state that earlier tests left behind
  task automatic t_mid_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clks(1);
    t_reset();
    rd_chk(16'h200C, 1'b0, 32'h0);
    $display("test mid reset done");
  endtask : t_mid_reset

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    sec = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    gerr_event = 8'h00;
    perf_event = 1'b0;
    lag = 8'h05;
    mismatches = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    clks(1);
    t_reset();
    t_ack();
    t_nonsec();
    t_holes();
    t_halves();
    t_init();
    t_gerr();
    t_perf();
    t_mid_reset();
    complete_run();
  end
endmodule : spra_top_bench
